// File: hw/emos_params.svh
`ifndef EMOS_PARAMS_SVH
`define EMOS_PARAMS_SVH

// register offsets
`define EMOS_A_SWING_A   8'h30
`define EMOS_A_DEEMPH_A  8'h31
`define EMOS_A_SWING_B   8'h32
`define EMOS_A_DEEMPH_B  8'h33
`define EMOS_A_OUT_FUNC  8'h34
`define EMOS_A_PIN_CFG   8'h35
`define EMOS_A_INT_MASK  8'h36
`define EMOS_A_INT_STAT  8'h37
`define EMOS_A_EYE_CTRL  8'h38
`define EMOS_A_EYE_SPAN  8'h39
`define EMOS_A_EYE_BITS  8'h3a
`define EMOS_A_EYE_PH    8'h3b
`define EMOS_A_EYE_VO    8'h3c
`define EMOS_A_HIT_LO    8'h3d
`define EMOS_A_HIT_HI    8'h3e
`define EMOS_A_WIDTH     8'h3f
`define EMOS_A_HEIGHT    8'h40
`define EMOS_A_THR_W     8'h41
`define EMOS_A_THR_H     8'h42

// field positions
`define EMOS_SWING_OVR_BIT  5
`define EMOS_DEEMPH_OVR_BIT 6
`define EMOS_FUNC_OVR_BIT   7
`define EMOS_CD_SEL_BIT     2
`define EMOS_EYE_START_BIT  0
`define EMOS_EYE_DONE_BIT   1
`define EMOS_EYE_UNSUP_BIT  2
`define EMOS_EYE_BUSY_BIT   3

// interrupt status / mask bits
`define EMOS_INT_COAX_LOSS  0
`define EMOS_INT_COAX_BACK  1
`define EMOS_INT_TRACE_LOSS 2
`define EMOS_INT_TRACE_BACK 3
`define EMOS_INT_EYE        4
`define EMOS_INT_LOCK       5
`define EMOS_INT_UNLOCK     6

// synchroniser vector positions
`define EMOS_SY_LOS_C  0
`define EMOS_SY_LOS_T  1
`define EMOS_SY_CD_C   2
`define EMOS_SY_CD_T   3
`define EMOS_SY_ADAPT  4
`define EMOS_SY_LOCK   5
`define EMOS_SY_GE297  6
`define EMOS_SY_GT3    7
`define EMOS_SY_10G    8

// strap thresholds in percent of the i/o supply
`define EMOS_THR_LR_PCT 20
`define EMOS_THR_RF_PCT 50
`define EMOS_THR_FH_PCT 80
`define EMOS_STRAP_FULL 256

// eye monitor
`define EMOS_EYE_MID      6'h20
`define EMOS_EYE_LAST     12'hfff
`define EMOS_SPAN_MAX_MV  400
`define EMOS_BITS_UNIT    17'h00100

// reset values
`define EMOS_RST_CODE     8'h00
`define EMOS_RST_SPAN     6'h3f
`define EMOS_RST_BITS     8'h00
`define EMOS_RST_THR      7'h00
`define EMOS_RST_MASK     7'h00

// drive codes selected by the strap levels
`define EMOS_DRV_H 3'h0
`define EMOS_DRV_F 3'h2
`define EMOS_DRV_R 3'h3
`define EMOS_DRV_L 3'h5

`endif

// File: hw/emos_pkg.sv
package emos_pkg;

  typedef enum logic [1:0] {LVL_L = 2'h0, LVL_R = 2'h1, LVL_F = 2'h2, LVL_H = 2'h3} emos_lvl_e;

  typedef enum logic [1:0] {
    FN_RAW  = 2'h0,
    FN_REC  = 2'h1,
    FN_EQ   = 2'h2,
    FN_RCLK = 2'h3
  } emos_fn_e;

  typedef enum logic [1:0] {PIN_LOCK = 2'h0, PIN_CD = 2'h1, PIN_INT = 2'h2} emos_pin_e;

  typedef enum logic [1:0] {EYE_IDLE = 2'b01, EYE_RUN = 2'b10} emos_eye_e;

  typedef struct packed {
    emos_fn_e   func_a;
    emos_fn_e   func_b;
    logic [2:0] swing_a;
    logic [2:0] deemph_a;
    logic [2:0] swing_b;
    logic [2:0] deemph_b;
    logic       clk_b_full_rate;
  } emos_drv_s;

  typedef struct packed {
    logic [8:0]  sync1;
    logic [8:0]  sync2;
    logic [8:0]  prev;
    logic [15:0] strap1;
    logic [15:0] strap2;
    emos_lvl_e   lvl_fn;
    emos_lvl_e   lvl_dl;
    logic [7:0]  r_swing_a;
    logic [7:0]  r_deemph_a;
    logic [7:0]  r_swing_b;
    logic [7:0]  r_deemph_b;
    logic [7:0]  r_func;
    logic [7:0]  r_pin;
    logic [6:0]  int_mask;
    logic [6:0]  int_stat;
    logic        eye_done;
    logic        eye_unsup;
    logic [5:0]  span;
    logic [7:0]  bits;
    logic [5:0]  rd_ph;
    logic [5:0]  rd_vo;
    logic [6:0]  thr_w;
    logic [6:0]  thr_h;
    emos_eye_e   eye;
    logic [11:0] pt;
    logic [16:0] bitcnt;
    logic [15:0] hitcnt;
    logic [6:0]  width;
    logic [6:0]  height;
    logic [6:0]  width_res;
    logic [6:0]  height_res;
    emos_drv_s   drv;
    logic        pin_low;
    logic [7:0]  rdata;
  } emos_state_s;

endpackage

// File: hw/emos_top.sv
// What this block does
// RULE1: eye captures run only at rates of 2.97 Gbps or more; else refused.
// RULE2: one unit interval and the voltage span split into 64 steps: 64x64 hits.
// RULE3: scanned voltage span is programmable, full scale is plus or minus 400 mV.
// RULE4: number of bits observed per eye point is programmable.
// RULE5: report eye width at zero volts and eye height at the centre phase.
// RULE6: output function follows the strap unless the register override is set.
// RULE7: strap H raw, F recovered, L equalized data on both outputs.
// RULE8: strap R recovered data on A, clock on B, full rate up to 3 Gbps.
// RULE9: host must not select recovered clock output at the 10GbE rate; the host model only replaces a recovered clock code for output B.
// RULE10: drive strap sets both outputs; overrides set each output separately.
// RULE11: drive strap H, F, R, L gives codes 0, 2, 3, 5 in 3-bit fields.
// RULE12: register-written swing and de-emphasis codes accept values up to 7.
// RULE13: status pin is active-low open drain, low on lock by default.
// RULE14: a register selects lock, carrier or interrupt on the status pin.
// RULE15: carrier mode goes low after adaptation with signal; register picks input.
// RULE16: interrupt mode goes low when any of seven enabled sources is set.
// RULE17: signal loss on coax and on trace input each raise two masked events.
// RULE18: eye width or height below threshold while locked raises one event.
// RULE19: recovery lock events raise two masked interrupts.
// RULE20: interrupt flags are sticky until the status register is read.
// RULE21: four-level straps decode with thresholds 0.2, 0.5, 0.8 of supply.
// RULE22: strap value applies only while override clear; override acts at once.
`include "emos_params.svh"
`timescale 1ns/100ps
`default_nettype none

module emos_top
(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // strap levels as fraction of i/o supply, 256 = full
  input  wire logic [7:0]       output_function_strap,
  input  wire logic [7:0]       drive_level_strap,
  // analog status, asynchronous
  input  wire logic             coax_input_signal_loss,
  input  wire logic             trace_input_signal_loss,
  input  wire logic             coax_input_carrier,
  input  wire logic             trace_input_carrier,
  input  wire logic             adapt_done,
  input  wire logic             cdr_lock,
  input  wire logic             rate_ge_2g97,
  input  wire logic             rate_gt_3g,
  input  wire logic             rate_10gbe,
  // eye monitor sampler, on ref_clk
  input  wire logic             eye_monitor_sample_vld,
  input  wire logic             eye_monitor_hit,
  output logic                  eye_monitor_en,
  output logic [5:0]            eye_monitor_phase,
  output logic [5:0]            eye_monitor_volt,
  output logic [5:0]            eye_monitor_span,
  // register port from the serial control decoder
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata,
  // output stage control
  output emos_pkg::emos_drv_s   drive_ctrl,
  // status pin, open drain
  output logic                  status_pin_o,
  output logic                  status_pin_oe
);
  import emos_pkg::*;

  emos_state_s  s_ff;
  emos_state_s  nxt_s;
  logic [15:0]  hit_mem [0:4095];
  logic         mem_we;
  logic [15:0]  hit_rd;

  function automatic emos_lvl_e lvl_decode(input logic [7:0] v);
    logic [15:0] scaled;
    scaled = {8'h00, v} * 16'd100;
    if (scaled >= 16'(`EMOS_THR_FH_PCT * `EMOS_STRAP_FULL))
      return LVL_H;
    else if (scaled >= 16'(`EMOS_THR_RF_PCT * `EMOS_STRAP_FULL))
      return LVL_F;
    else if (scaled >= 16'(`EMOS_THR_LR_PCT * `EMOS_STRAP_FULL))
      return LVL_R;
    else
      return LVL_L;
  endfunction

  function automatic logic [2:0] drv_code(input emos_lvl_e l);
    case (l)
      LVL_H:   return `EMOS_DRV_H;
      LVL_F:   return `EMOS_DRV_F;
      LVL_R:   return `EMOS_DRV_R;
      default: return `EMOS_DRV_L;
    endcase
  endfunction

  function automatic logic [2:0] pick(input logic [7:0] r, input int ob, input emos_lvl_e l);
    return r[ob] ? r[2:0] : drv_code(l);
  endfunction

  logic [16:0] bits_target;
  logic        pt_adv;
  logic        rd_int;
  logic [6:0]  ev;
  logic        eye_ev;
  logic [6:0]  w_new;
  logic [6:0]  h_new;

  assign hit_rd = hit_mem[{s_ff.rd_ph, s_ff.rd_vo}];
  // code n observes (n+1)*256 bits per point
  assign bits_target = {1'b0, s_ff.bits, 8'h00} + `EMOS_BITS_UNIT; // [RULE4]
  assign pt_adv = (s_ff.eye == EYE_RUN) && eye_monitor_sample_vld
                  && (s_ff.bitcnt + 17'h00001 == bits_target);
  assign rd_int = reg_rd && (reg_addr == `EMOS_A_INT_STAT);

  always_comb
  begin
    nxt_s  = s_ff;
    mem_we = 1'b0;
    eye_ev = 1'b0;
    w_new  = s_ff.width;
    h_new  = s_ff.height;
    nxt_s.sync1  = {rate_10gbe, rate_gt_3g, rate_ge_2g97, cdr_lock, adapt_done,
                    trace_input_carrier, coax_input_carrier,
                    trace_input_signal_loss, coax_input_signal_loss};
    nxt_s.sync2  = s_ff.sync1;
    nxt_s.prev   = s_ff.sync2;
    nxt_s.strap1 = {output_function_strap, drive_level_strap};
    nxt_s.strap2 = s_ff.strap1;
    nxt_s.lvl_fn = lvl_decode(s_ff.strap2[15:8]); // [RULE21]
    nxt_s.lvl_dl = lvl_decode(s_ff.strap2[7:0]); // [RULE21]

    if (reg_wr)
    begin
      case (reg_addr)
        `EMOS_A_SWING_A:  nxt_s.r_swing_a = reg_wdata; // [RULE12]
        `EMOS_A_DEEMPH_A: nxt_s.r_deemph_a = reg_wdata;
        `EMOS_A_SWING_B:  nxt_s.r_swing_b = reg_wdata;
        `EMOS_A_DEEMPH_B: nxt_s.r_deemph_b = reg_wdata;
        `EMOS_A_OUT_FUNC: nxt_s.r_func = reg_wdata;
        `EMOS_A_PIN_CFG:  nxt_s.r_pin = reg_wdata; // [RULE14]
        `EMOS_A_INT_MASK: nxt_s.int_mask = reg_wdata[6:0];
        `EMOS_A_EYE_SPAN: nxt_s.span = reg_wdata[5:0]; // [RULE3]
        `EMOS_A_EYE_BITS: nxt_s.bits = reg_wdata;
        `EMOS_A_EYE_PH:   nxt_s.rd_ph = reg_wdata[5:0];
        `EMOS_A_EYE_VO:   nxt_s.rd_vo = reg_wdata[5:0];
        `EMOS_A_THR_W:    nxt_s.thr_w = reg_wdata[6:0];
        `EMOS_A_THR_H:    nxt_s.thr_h = reg_wdata[6:0];
        default:          nxt_s.rdata = s_ff.rdata;
      endcase
    end

    // eye scan: phase outer, voltage inner
    case (s_ff.eye)
      EYE_IDLE:
      begin
        if (reg_wr && reg_addr == `EMOS_A_EYE_CTRL && reg_wdata[`EMOS_EYE_START_BIT])
        begin
          nxt_s.eye_done = 1'b0;
          if (s_ff.sync2[`EMOS_SY_GE297])
          begin
            nxt_s.eye_unsup = 1'b0;
            nxt_s.eye    = EYE_RUN;
            nxt_s.pt     = 12'h000;
            nxt_s.bitcnt = 17'h00000;
            nxt_s.hitcnt = 16'h0000;
            nxt_s.width  = 7'h00;
            nxt_s.height = 7'h00;
          end
          else
            nxt_s.eye_unsup = 1'b1; // [RULE1]
        end
      end
      EYE_RUN:
      begin
        if (!s_ff.sync2[`EMOS_SY_GE297])
        begin
          // rate fell mid scan: the array would mix rates, so give up
          nxt_s.eye_unsup = 1'b1; // [RULE1]
          nxt_s.eye       = EYE_IDLE;
        end
        else if (eye_monitor_sample_vld)
        begin
          if (eye_monitor_hit && s_ff.hitcnt != 16'hffff)
            nxt_s.hitcnt = s_ff.hitcnt + 16'h0001;
          nxt_s.bitcnt = s_ff.bitcnt + 17'h00001;
          if (pt_adv)
          begin
            mem_we = 1'b1; // [RULE2]
            if (s_ff.pt[5:0] == `EMOS_EYE_MID && s_ff.hitcnt == 16'h0000 && !eye_monitor_hit)
              w_new = s_ff.width + 7'h01; // [RULE5]
            if (s_ff.pt[11:6] == `EMOS_EYE_MID && s_ff.hitcnt == 16'h0000 && !eye_monitor_hit)
              h_new = s_ff.height + 7'h01; // [RULE5]
            nxt_s.width  = w_new;
            nxt_s.height = h_new;
            nxt_s.bitcnt = 17'h00000;
            nxt_s.hitcnt = 16'h0000;
            nxt_s.pt     = s_ff.pt + 12'h001;
            if (s_ff.pt == `EMOS_EYE_LAST)
            begin
              nxt_s.eye        = EYE_IDLE;
              nxt_s.eye_done   = 1'b1;
              nxt_s.width_res  = w_new;
              nxt_s.height_res = h_new;
              eye_ev = s_ff.sync2[`EMOS_SY_LOCK]
                       && (w_new < s_ff.thr_w || h_new < s_ff.thr_h); // [RULE18]
            end
          end
        end
      end
      default: nxt_s.eye = EYE_IDLE;
    endcase

    // events, each edge of a level gets its own mask bit
    ev = 7'h00;
    ev[`EMOS_INT_COAX_LOSS]  = s_ff.sync2[`EMOS_SY_LOS_C] & ~s_ff.prev[`EMOS_SY_LOS_C]; // [RULE17]
    ev[`EMOS_INT_COAX_BACK]  = ~s_ff.sync2[`EMOS_SY_LOS_C] & s_ff.prev[`EMOS_SY_LOS_C]; // [RULE17]
    ev[`EMOS_INT_TRACE_LOSS] = s_ff.sync2[`EMOS_SY_LOS_T] & ~s_ff.prev[`EMOS_SY_LOS_T]; // [RULE17]
    ev[`EMOS_INT_TRACE_BACK] = ~s_ff.sync2[`EMOS_SY_LOS_T] & s_ff.prev[`EMOS_SY_LOS_T]; // [RULE17]
    ev[`EMOS_INT_EYE]        = eye_ev; // [RULE18]
    ev[`EMOS_INT_LOCK]       = s_ff.sync2[`EMOS_SY_LOCK] & ~s_ff.prev[`EMOS_SY_LOCK]; // [RULE19]
    ev[`EMOS_INT_UNLOCK]     = ~s_ff.sync2[`EMOS_SY_LOCK] & s_ff.prev[`EMOS_SY_LOCK]; // [RULE19]
    // new event wins over the clearing read
    nxt_s.int_stat = (rd_int ? 7'h00 : s_ff.int_stat) | ev; // [RULE20]

    nxt_s.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `EMOS_A_SWING_A:  nxt_s.rdata = s_ff.r_swing_a;
        `EMOS_A_DEEMPH_A: nxt_s.rdata = s_ff.r_deemph_a;
        `EMOS_A_SWING_B:  nxt_s.rdata = s_ff.r_swing_b;
        `EMOS_A_DEEMPH_B: nxt_s.rdata = s_ff.r_deemph_b;
        `EMOS_A_OUT_FUNC: nxt_s.rdata = s_ff.r_func;
        `EMOS_A_PIN_CFG:  nxt_s.rdata = s_ff.r_pin;
        `EMOS_A_INT_MASK: nxt_s.rdata = {1'b0, s_ff.int_mask};
        `EMOS_A_INT_STAT: nxt_s.rdata = {1'b0, s_ff.int_stat};
        `EMOS_A_EYE_CTRL: nxt_s.rdata = {4'h0, s_ff.eye == EYE_RUN, s_ff.eye_unsup,
                                         s_ff.eye_done, 1'b0};
        `EMOS_A_EYE_SPAN: nxt_s.rdata = {2'h0, s_ff.span};
        `EMOS_A_EYE_BITS: nxt_s.rdata = s_ff.bits;
        `EMOS_A_EYE_PH:   nxt_s.rdata = {2'h0, s_ff.rd_ph};
        `EMOS_A_EYE_VO:   nxt_s.rdata = {2'h0, s_ff.rd_vo};
        `EMOS_A_HIT_LO:   nxt_s.rdata = hit_rd[7:0];
        `EMOS_A_HIT_HI:   nxt_s.rdata = hit_rd[15:8];
        `EMOS_A_WIDTH:    nxt_s.rdata = {1'b0, s_ff.width_res}; // [RULE5]
        `EMOS_A_HEIGHT:   nxt_s.rdata = {1'b0, s_ff.height_res}; // [RULE5]
        `EMOS_A_THR_W:    nxt_s.rdata = {1'b0, s_ff.thr_w};
        `EMOS_A_THR_H:    nxt_s.rdata = {1'b0, s_ff.thr_h};
        default:          nxt_s.rdata = 8'h00;
      endcase
    end

    // output function from strap or override
    if (s_ff.r_func[`EMOS_FUNC_OVR_BIT])
    begin
      nxt_s.drv.func_a = emos_fn_e'(s_ff.r_func[1:0]); // [RULE6] [RULE22]
      nxt_s.drv.func_b = emos_fn_e'(s_ff.r_func[3:2]); // [RULE6] [RULE22]
    end
    else
    begin
      case (s_ff.lvl_fn)
        LVL_H:   nxt_s.drv.func_a = FN_RAW; // [RULE7]
        LVL_F:   nxt_s.drv.func_a = FN_REC; // [RULE7]
        LVL_R:   nxt_s.drv.func_a = FN_REC; // [RULE8]
        default: nxt_s.drv.func_a = FN_EQ; // [RULE7]
      endcase
      nxt_s.drv.func_b = (s_ff.lvl_fn == LVL_R) ? FN_RCLK : nxt_s.drv.func_a; // [RULE8]
    end
    // full-rate clock at 3 Gbps and below, divided clock above
    nxt_s.drv.clk_b_full_rate = ~s_ff.sync2[`EMOS_SY_GT3]; // [RULE8]
    nxt_s.drv.swing_a  = pick(s_ff.r_swing_a, `EMOS_SWING_OVR_BIT, s_ff.lvl_dl); // [RULE10] [RULE11]
    nxt_s.drv.deemph_a = pick(s_ff.r_deemph_a, `EMOS_DEEMPH_OVR_BIT, s_ff.lvl_dl); // [RULE10]
    nxt_s.drv.swing_b  = pick(s_ff.r_swing_b, `EMOS_SWING_OVR_BIT, s_ff.lvl_dl); // [RULE10]
    nxt_s.drv.deemph_b = pick(s_ff.r_deemph_b, `EMOS_DEEMPH_OVR_BIT, s_ff.lvl_dl); // [RULE10]

    case (emos_pin_e'(s_ff.r_pin[1:0]))
      PIN_LOCK: nxt_s.pin_low = s_ff.sync2[`EMOS_SY_LOCK]; // [RULE13]
      PIN_CD:   nxt_s.pin_low = s_ff.sync2[`EMOS_SY_ADAPT] & (s_ff.r_pin[`EMOS_CD_SEL_BIT]
                                ? s_ff.sync2[`EMOS_SY_CD_T] : s_ff.sync2[`EMOS_SY_CD_C]); // [RULE15]
      PIN_INT:  nxt_s.pin_low = |(s_ff.int_stat & s_ff.int_mask); // [RULE16]
      default:  nxt_s.pin_low = s_ff.sync2[`EMOS_SY_LOCK];
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s_ff            <= '0;
      s_ff.lvl_fn     <= LVL_L;
      s_ff.lvl_dl     <= LVL_L;
      s_ff.r_swing_a  <= `EMOS_RST_CODE;
      s_ff.r_deemph_a <= `EMOS_RST_CODE;
      s_ff.r_swing_b  <= `EMOS_RST_CODE;
      s_ff.r_deemph_b <= `EMOS_RST_CODE;
      s_ff.r_func     <= `EMOS_RST_CODE;
      s_ff.r_pin      <= `EMOS_RST_CODE;
      s_ff.int_mask   <= `EMOS_RST_MASK;
      s_ff.span       <= `EMOS_RST_SPAN;
      s_ff.bits       <= `EMOS_RST_BITS;
      s_ff.thr_w      <= `EMOS_RST_THR;
      s_ff.thr_h      <= `EMOS_RST_THR;
      s_ff.eye        <= EYE_IDLE;
    end
    else
      s_ff <= nxt_s;
  end

  // hit array, no reset needed: only read after a scan fills it
  always_ff @(posedge ref_clk)
  begin
    if (mem_we)
      hit_mem[s_ff.pt] <= eye_monitor_hit && s_ff.hitcnt != 16'hffff
                          ? s_ff.hitcnt + 16'h0001 : s_ff.hitcnt;
  end

  assign eye_monitor_en    = (s_ff.eye == EYE_RUN);
  assign eye_monitor_phase = s_ff.pt[11:6];
  assign eye_monitor_volt  = s_ff.pt[5:0];
  assign eye_monitor_span  = s_ff.span;
  assign reg_rdata         = s_ff.rdata;
  assign drive_ctrl        = s_ff.drv;
  assign status_pin_o      = 1'b0;
  assign status_pin_oe     = s_ff.pin_low;

  property p_unsup;
    @(posedge ref_clk) disable iff (sys_rst)
    (s_ff.eye == EYE_IDLE && reg_wr && reg_addr == `EMOS_A_EYE_CTRL && reg_wdata[0]
     && !s_ff.sync2[`EMOS_SY_GE297]) |=> (s_ff.eye_unsup && s_ff.eye == EYE_IDLE);
  endproperty
  a_unsup: assert property (p_unsup) else $error("start at low rate not refused"); // [RULE1]

  property p_adv;
    @(posedge ref_clk) disable iff (sys_rst)
    (s_ff.eye == EYE_RUN && eye_monitor_sample_vld && s_ff.sync2[`EMOS_SY_GE297]
     && s_ff.bitcnt + 17'h00001 == bits_target) |=> (s_ff.pt == $past(s_ff.pt) + 12'h001);
  endproperty
  a_adv: assert property (p_adv) else $error("point did not advance after bit count"); // [RULE4]

  property p_end;
    @(posedge ref_clk) disable iff (sys_rst)
    (pt_adv && s_ff.sync2[`EMOS_SY_GE297] && s_ff.pt == `EMOS_EYE_LAST)
      |=> (s_ff.eye == EYE_IDLE && s_ff.eye_done);
  endproperty
  a_end: assert property (p_end) else $error("scan did not end after 4096 points"); // [RULE2]

  property p_span;
    @(posedge ref_clk) disable iff (sys_rst)
    (reg_wr && reg_addr == `EMOS_A_EYE_SPAN) |=> (eye_monitor_span == $past(reg_wdata[5:0]));
  endproperty
  a_span: assert property (p_span) else $error("span write not applied"); // [RULE3]

  property p_ovr;
    @(posedge ref_clk) disable iff (sys_rst)
    s_ff.r_func[`EMOS_FUNC_OVR_BIT] |=> (drive_ctrl.func_a == $past(s_ff.r_func[1:0]));
  endproperty
  a_ovr: assert property (p_ovr) else $error("function override not applied"); // [RULE6]

  property p_strap_h;
    @(posedge ref_clk) disable iff (sys_rst)
    (!s_ff.r_func[`EMOS_FUNC_OVR_BIT] && s_ff.lvl_fn == LVL_H)
      |=> (drive_ctrl.func_a == FN_RAW && drive_ctrl.func_b == FN_RAW);
  endproperty
  a_strap_h: assert property (p_strap_h) else $error("strap H not raw on both"); // [RULE7]

  property p_drv_f;
    @(posedge ref_clk) disable iff (sys_rst)
    (!s_ff.r_swing_b[`EMOS_SWING_OVR_BIT] && s_ff.lvl_dl == LVL_F) |=> (drive_ctrl.swing_b == 3'h2);
  endproperty
  a_drv_f: assert property (p_drv_f) else $error("drive strap F not code 2"); // [RULE11]

  property p_sticky;
    @(posedge ref_clk) disable iff (sys_rst)
    (s_ff.int_stat != 7'h00 && !rd_int) |=> (s_ff.int_stat != 7'h00);
  endproperty
  a_sticky: assert property (p_sticky) else $error("interrupt flag lost without read"); // [RULE20]

  property p_int_pin;
    @(posedge ref_clk) disable iff (sys_rst)
    (s_ff.r_pin[1:0] == PIN_INT && |(s_ff.int_stat & s_ff.int_mask)) |=> status_pin_oe;
  endproperty
  a_int_pin: assert property (p_int_pin) else $error("enabled interrupt not on pin"); // [RULE16]

  property p_lock_pin;
    @(posedge ref_clk) disable iff (sys_rst)
    (s_ff.r_pin[1:0] == PIN_LOCK) |=> (status_pin_oe == $past(s_ff.sync2[`EMOS_SY_LOCK]));
  endproperty
  a_lock_pin: assert property (p_lock_pin) else $error("lock not shown on pin"); // [RULE13]

endmodule

`default_nettype wire

// File: sim/emos_host.sv
`include "emos_params.svh"
`timescale 1ns/100ps
`default_nettype none

// host behind the serial control decoder
module emos_host
(
  // clock and status
  input  wire logic       ref_clk,
  input  wire logic       rate_10gbe,
  // register port
  input  wire logic [7:0] reg_rdata,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    // recovered clock is video only, so fall back to data at the ethernet rate
    if (a == `EMOS_A_OUT_FUNC && rate_10gbe && d[3:2] == 2'h3)
      d[3:2] = 2'h1;
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    // released lines must not look like a held value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

`default_nettype wire

// File: sim/test_eye_monitor_output_status.sv
`include "emos_params.svh"
`timescale 1ns/100ps
`default_nettype none

module test_eye_monitor_output_status;
  import emos_pkg::*;
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
  logic ref_clk, sys_rst, coax_input_signal_loss, trace_input_signal_loss;
  logic coax_input_carrier, trace_input_carrier, adapt_done, cdr_lock, rate_ge_2g97;
  logic rate_gt_3g, rate_10gbe, eye_monitor_sample_vld, eye_monitor_hit, eye_monitor_en;
  logic reg_wr, reg_rd, status_pin_o, status_pin_oe;
  logic [7:0] output_function_strap, drive_level_strap, reg_addr, reg_wdata, reg_rdata, d;
  logic [5:0] eye_monitor_phase, eye_monitor_volt, eye_monitor_span;
  emos_drv_s drive_ctrl;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  emos_top emos_top_inst (.ref_clk, .sys_rst, .output_function_strap, .drive_level_strap,
    .coax_input_signal_loss, .trace_input_signal_loss, .coax_input_carrier,
    .trace_input_carrier, .adapt_done, .cdr_lock, .rate_ge_2g97, .rate_gt_3g, .rate_10gbe,
    .eye_monitor_sample_vld, .eye_monitor_hit, .eye_monitor_en, .eye_monitor_phase,
    .eye_monitor_volt, .eye_monitor_span, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .drive_ctrl, .status_pin_o, .status_pin_oe);
  emos_host emos_host_inst (.ref_clk, .rate_10gbe, .reg_rdata, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd);

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic complete_run();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ceiling well above the few hundred cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
  end

  task automatic t_straps();
    logic [7:0] v [4] = '{8'h00, 8'h55, 8'haa, 8'hff};
    logic [2:0] c [4] = '{`EMOS_DRV_L, `EMOS_DRV_R, `EMOS_DRV_F, `EMOS_DRV_H};
    emos_fn_e fa [4] = '{FN_EQ, FN_REC, FN_REC, FN_RAW};
    emos_fn_e fb [4] = '{FN_EQ, FN_RCLK, FN_REC, FN_RAW};
    for (int i = 0; i < 4; i++)
    begin
      output_function_strap = v[i];
      drive_level_strap = v[i];
      rate_gt_3g = i[0];
      tick(8);
      `CHK("swing_a", c[i], drive_ctrl.swing_a)
      `CHK("deemph_b", c[i], drive_ctrl.deemph_b)
      `CHK("func_a", fa[i], drive_ctrl.func_a)
      `CHK("func_b", fb[i], drive_ctrl.func_b)
      `CHK("clk_full", ~i[0], drive_ctrl.clk_b_full_rate)
    end
  endtask

  task automatic t_override();
    // back to strap L so the drive strap defaults differ from the override codes
    output_function_strap = 8'h00;
    drive_level_strap = 8'h00;
    for (int a = 8'h30; a < 8'h34; a++)
    begin
      emos_host_inst.rd(a[7:0], d);
      `CHK("reset_value", 8'h00, d)
    end
    emos_host_inst.wr(8'h30, 8'h27);
    emos_host_inst.wr(8'h33, 8'h46);
    emos_host_inst.wr(8'h34, 8'h89);
    tick(2);
    `CHK("swing_a", 3'h7, drive_ctrl.swing_a)
    `CHK("deemph_a", `EMOS_DRV_L, drive_ctrl.deemph_a)
    `CHK("deemph_b", 3'h6, drive_ctrl.deemph_b)
    `CHK("func_b", FN_EQ, drive_ctrl.func_b)
    emos_host_inst.rd(8'h30, d);
    `CHK("rw_back", 8'h27, d)
    emos_host_inst.rd(8'h80, d);
    `CHK("unmapped", 8'h00, d)
    rate_10gbe = 1'b1;
    emos_host_inst.wr(8'h34, 8'h8d);
    tick(2);
    `CHK("func_b_10g", FN_REC, drive_ctrl.func_b)
    rate_10gbe = 1'b0;
    emos_host_inst.wr(8'h30, 8'h07);
    emos_host_inst.wr(8'h34, 8'h00);
    tick(2);
    `CHK("swing_a", `EMOS_DRV_L, drive_ctrl.swing_a)
    `CHK("func_a", FN_EQ, drive_ctrl.func_a)
  endtask

  task automatic t_status();
    tick(4);
    `CHK("lock_off", 1'b0, status_pin_oe)
    cdr_lock = 1'b1;
    tick(4);
    `CHK("lock_on", 1'b1, status_pin_oe)
    `CHK("pin_level", 1'b0, status_pin_o)
    emos_host_inst.wr(8'h35, 8'h01);
    coax_input_carrier = 1'b1;
    adapt_done = 1'b1;
    tick(4);
    `CHK("carrier_coax", 1'b1, status_pin_oe)
    emos_host_inst.wr(8'h35, 8'h05);
    tick(4);
    `CHK("carrier_trace", 1'b0, status_pin_oe)
  endtask

  task automatic t_int();
    emos_host_inst.wr(8'h36, 8'h7f);
    emos_host_inst.rd(8'h37, d);
    emos_host_inst.wr(8'h35, 8'h02);
    tick(2);
    `CHK("int_idle", 1'b0, status_pin_oe)
    coax_input_signal_loss = 1'b1;
    tick(4);
    `CHK("int_set", 1'b1, status_pin_oe)
    tick(6);
    `CHK("int_sticky", 1'b1, status_pin_oe)
    emos_host_inst.rd(8'h37, d);
    `CHK("int_stat", 8'h01, d)
    tick(2);
    `CHK("int_clear", 1'b0, status_pin_oe)
    cdr_lock = 1'b0;
    trace_input_signal_loss = 1'b1;
    tick(4);
    emos_host_inst.rd(8'h37, d);
    `CHK("int_stat", 8'h44, d)
    emos_host_inst.wr(8'h36, 8'h00);
    coax_input_signal_loss = 1'b0;
    tick(4);
    `CHK("int_masked", 1'b0, status_pin_oe)
  endtask

  task automatic t_eye();
    rate_ge_2g97 = 1'b0;
    emos_host_inst.wr(8'h38, 8'h01);
    tick(2);
    `CHK("eye_refused", 1'b0, eye_monitor_en)
    emos_host_inst.rd(8'h38, d);
    `CHK("eye_unsup", 1'b1, d[2])
    rate_ge_2g97 = 1'b1;
    emos_host_inst.rd(8'h39, d);
    `CHK("span_reset", 8'h3f, d)
    `CHK("span_out", 6'h3f, eye_monitor_span)
    emos_host_inst.wr(8'h3a, 8'h01);
    tick(4);
    emos_host_inst.wr(8'h38, 8'h01);
    tick(1);
    `CHK("eye_en", 1'b1, eye_monitor_en)
    `CHK("eye_volt", 6'h00, eye_monitor_volt)
    eye_monitor_sample_vld = 1'b1;
    eye_monitor_hit = 1'b1;
    tick(506);
    `CHK("eye_volt", 6'h00, eye_monitor_volt)
    tick(10);
    eye_monitor_sample_vld = 1'b0;
    `CHK("eye_volt", 6'h01, eye_monitor_volt)
    `CHK("eye_phase", 6'h00, eye_monitor_phase)
    rate_ge_2g97 = 1'b0;
    tick(6);
    `CHK("eye_abort", 1'b0, eye_monitor_en)
  endtask

  initial
  begin
    {coax_input_signal_loss, trace_input_signal_loss, coax_input_carrier} = 3'h0;
    {trace_input_carrier, adapt_done, cdr_lock, rate_ge_2g97, rate_gt_3g} = 5'h0;
    {rate_10gbe, eye_monitor_sample_vld, eye_monitor_hit} = 3'h0;
    output_function_strap = 8'h00;
    drive_level_strap = 8'h00;
    sys_rst = 1'b1;
    tick(6);
    sys_rst = 1'b0;
    t_straps();
    t_override();
    t_status();
    t_int();
    t_eye();
    complete_run();
  end
endmodule

`default_nettype wire
